// ==== ddrm_core.sv ====
/*
 DDR SDRAM device model: command decoder, bank rows, mode registers,
 double-rate read launch and strobe-captured writes, APB status port.
 Assumes every DDR pin is asynchronous to I_CLK_SYS and that CK is slow enough
 (at least eight system clocks per half period) to be sampled.
*/
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "ddrm_defines.svh"
module ddrm_core #(
	parameter int COL_W = 4,
	parameter int LANES = 2
) (
	// System
	input wire logic I_CLK_SYS,
	input wire logic I_RST_N,
	// APB
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	// Clock and command pins
	input wire logic I_CK,
	input wire logic I_CKE,
	input wire logic I_CS_N,
	input wire logic I_RAS_N,
	input wire logic I_CAS_N,
	input wire logic I_WE_N,
	input wire logic [1:0] I_BA,
	input wire logic [13:0] I_A,
	// Data pins
	input wire logic [8*LANES-1:0] I_DQ,
	output logic [8*LANES-1:0] O_DQ,
	output logic O_DQ_OE,
	input wire logic [LANES-1:0] I_DQS,
	output logic [LANES-1:0] O_DQS,
	output logic [LANES-1:0] O_DQS_OE,
	input wire logic [LANES-1:0] I_DM
);
	localparam int DW = 8 * LANES;
	localparam int PW = 22 + DW + 2 * LANES;
	logic [PW-1:0] in_m_r, in_s_r;
	logic ck_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, ck_d_r;
	logic [1:0] ba_s;
	logic [13:0] a_s;
	logic [DW-1:0] dq_s;
	logic [LANES-1:0] dqs_s, dm_s, dqs_d_r;
	logic ck_rise, ck_edge, ck_fall;
	ddrm_pkg::ddrm_cmd_e cmd;
	logic ctrl_en_r, err_r;
	logic [13:0] mode_r, emode_r;
	logic [3:0] open_r;
	logic [13:0] row_r [4];
	logic [7:0] dll_cnt_r;
	logic [1:0] rd_bank_r, wr_bank_r;
	logic [COL_W-1:0] rd_col_r, wr_col_r, rd_a0, rd_a1;
	logic [2:0] rd_wait_r;
	logic [3:0] rd_idx_r, bl_len;
	logic rd_on_r, rd_post_r, wr_go, stat_wr;
	logic [DW-1:0] rd_lo, rd_hi, hold_r;
	logic [LANES-1:0] wr_act;
	logic [31:0] rdata;
	logic hit;

	// Every DDR pin passes two flops; the first stage feeds only the second
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			in_m_r <= '0;
			in_s_r <= '0;
		end else begin
			in_m_r <= {I_CK, I_CKE, I_CS_N, I_RAS_N, I_CAS_N, I_WE_N, I_BA, I_A, I_DQ, I_DQS, I_DM};
			in_s_r <= in_m_r;
		end
	end
	assign {ck_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s, a_s, dq_s, dqs_s, dm_s} = in_s_r;

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			ck_d_r <= 1'b0;
			dqs_d_r <= '0;
		end else begin
			ck_d_r <= ck_s;
			dqs_d_r <= dqs_s;
		end
	end
	assign ck_rise = ck_s & ~ck_d_r;
	assign ck_fall = ~ck_s & ck_d_r;
	assign ck_edge = ck_rise | ck_fall;

	// Commands count only at a CK rise with CKE high and the block enabled
	always_comb begin
		cmd = ddrm_pkg::CMD_NOP;
		if (ck_rise && cke_s && ctrl_en_r && !cs_n_s) begin
			unique case ({ras_n_s, cas_n_s, we_n_s})
				3'h3: cmd = ddrm_pkg::CMD_ACT;
				3'h5: cmd = ddrm_pkg::CMD_RD;
				3'h4: cmd = ddrm_pkg::CMD_WR;
				3'h2: cmd = ddrm_pkg::CMD_PRE;
				3'h1: cmd = ddrm_pkg::CMD_REF;
				3'h0: cmd = ddrm_pkg::CMD_LMR;
				3'h6: cmd = ddrm_pkg::CMD_BST;
				3'h7: cmd = ddrm_pkg::CMD_NOP;
			endcase
		end
	end

	// Bank rows; accesses to a closed bank are dropped
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			open_r <= '0;
			for (int i = 0; i < 4; i++) row_r[i] <= '0;
		end else if (cmd == ddrm_pkg::CMD_ACT) begin
			open_r[ba_s] <= 1'b1;
			row_r[ba_s] <= a_s;
		end else if (cmd == ddrm_pkg::CMD_PRE) begin
			if (a_s[`DDRM_AP_BIT])
				open_r <= '0;
			else
				open_r[ba_s] <= 1'b0;
		end
	end

	// Mode registers; DLL-reset bit is dropped one cycle after it lands
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			mode_r <= '0;
			emode_r <= '0;
		end else if (cmd == ddrm_pkg::CMD_LMR && ba_s == `DDRM_BA_MR) begin
			mode_r <= a_s;
		end else if (cmd == ddrm_pkg::CMD_LMR && ba_s == `DDRM_BA_EMR) begin
			emode_r <= a_s;
		end else begin
			mode_r[`DDRM_MR_DLLRST] <= 1'b0;
		end
	end

	// DLL lock counter and reserved-mode flag (set wins over clear)
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			dll_cnt_r <= '0;
			err_r <= 1'b0;
		end else begin
			if (cmd == ddrm_pkg::CMD_LMR && ba_s == `DDRM_BA_MR
					&& a_s[`DDRM_MR_OP] == `DDRM_OP_DLLRST)
				dll_cnt_r <= '0;
			else if (ck_rise && dll_cnt_r != `DDRM_DLL_CYC)
				dll_cnt_r <= dll_cnt_r + 8'h1;
			if (cmd == ddrm_pkg::CMD_LMR && ba_s == `DDRM_BA_MR
					&& a_s[`DDRM_MR_OP] != `DDRM_OP_NORMAL
					&& a_s[`DDRM_MR_OP] != `DDRM_OP_DLLRST)
				err_r <= 1'b1;
			else if (stat_wr && I_PWDATA[`DDRM_ST_ERR])
				err_r <= 1'b0;
		end
	end

	// Burst length in words; reserved codes are not meaningful
	assign bl_len = 4'(1) << mode_r[1:0];

	function automatic logic [COL_W-1:0] col_of(input logic [COL_W-1:0] s,
			input logic [3:0] k, input logic [1:0] sh, input logic itl);
		logic [COL_W-1:0] m;
		logic [COL_W-1:0] o;
		m = COL_W'((4'(1) << sh) - 4'(1));
		o = itl ? (s ^ COL_W'(k)) : (s + COL_W'(k));
		return (s & ~m) | (o & m);
	endfunction

	// Start column of each burst
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rd_bank_r <= '0;
			rd_col_r <= '0;
			wr_bank_r <= '0;
			wr_col_r <= '0;
		end else if (cmd == ddrm_pkg::CMD_RD && open_r[ba_s]) begin
			rd_bank_r <= ba_s;
			rd_col_r <= a_s[COL_W-1:0];
		end else if (wr_go) begin
			wr_bank_r <= ba_s;
			wr_col_r <= a_s[COL_W-1:0];
		end
	end
	assign wr_go = (cmd == ddrm_pkg::CMD_WR) && open_r[ba_s];

	assign rd_a0 = col_of(rd_col_r, rd_idx_r, mode_r[1:0], mode_r[`DDRM_MR_BT]);
	assign rd_a1 = col_of(rd_col_r, rd_idx_r + 4'h1, mode_r[1:0], mode_r[`DDRM_MR_BT]);

	// Per byte lane: storage, strobe-captured writes, read fetch
	for (genvar b = 0; b < LANES; b++) begin : g_lane
		logic [7:0] mem_r [4 << COL_W];
		logic [3:0] idx_r;
		logic act_r;
		logic [COL_W-1:0] wa;
		logic stb;
		assign stb = dqs_s[b] ^ dqs_d_r[b];
		assign wa = col_of(wr_col_r, idx_r, mode_r[1:0], mode_r[`DDRM_MR_BT]);
		assign wr_act[b] = act_r;
		always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
			if (!I_RST_N) begin
				idx_r <= '0;
				act_r <= 1'b0;
			end else if (wr_go) begin
				idx_r <= '0;
				act_r <= 1'b1;
			end else if (act_r && stb) begin
				idx_r <= idx_r + 4'h1;
				act_r <= (idx_r + 4'h1) != bl_len;
			end
		end
		// Row bits do not reach the array, so rows alias: a small model
		always_ff @(posedge I_CLK_SYS) begin
			if (act_r && stb && !dm_s[b])
				mem_r[{wr_bank_r, wa}] <= dq_s[8*b +: 8];
		end
		assign rd_lo[8*b +: 8] = mem_r[{rd_bank_r, rd_a0}];
		assign rd_hi[8*b +: 8] = mem_r[{rd_bank_r, rd_a1}];
	end

	// Read launch: count CK half periods, then one word per CK edge
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rd_wait_r <= '0;
			rd_idx_r <= '0;
			rd_on_r <= 1'b0;
			rd_post_r <= 1'b0;
			hold_r <= '0;
			O_DQ <= '0;
			O_DQ_OE <= 1'b0;
			O_DQS <= '0;
			O_DQS_OE <= '0;
		end else if (cmd == ddrm_pkg::CMD_RD && open_r[ba_s]) begin
			rd_wait_r <= (mode_r[`DDRM_MR_CL] == `DDRM_CL25) ? `DDRM_CL25_HALF
				: `DDRM_CL2_HALF;
			rd_idx_r <= '0;
			rd_on_r <= 1'b0;
			// A restart drops the interrupted burst so stale data is not driven
			O_DQ_OE <= 1'b0;
		end else if (ck_edge) begin
			if (rd_wait_r > 3'h1) begin
				rd_wait_r <= rd_wait_r - 3'h1;
				if (rd_wait_r == 3'h2) begin
					O_DQS_OE <= '1;
					O_DQS <= '0;
				end
			end else if (rd_wait_r == 3'h1 || (rd_on_r && rd_idx_r != bl_len)) begin
				rd_wait_r <= '0;
				rd_on_r <= 1'b1;
				rd_idx_r <= rd_idx_r + 4'h1;
				O_DQ_OE <= 1'b1;
				O_DQS <= {LANES{~rd_idx_r[0]}};
				if (!rd_idx_r[0]) begin
					O_DQ <= rd_lo;
					hold_r <= rd_hi;
				end else begin
					O_DQ <= hold_r;
				end
			end else if (rd_on_r) begin
				rd_on_r <= 1'b0;
				rd_post_r <= 1'b1;
				O_DQ_OE <= 1'b0;
				O_DQS <= '0;
			end else if (rd_post_r) begin
				rd_post_r <= 1'b0;
				O_DQS_OE <= '0;
			end
		end
	end

	// APB slave: zero wait, read data registered in the setup cycle
	assign hit = I_PADDR == `DDRM_OFF_CTRL || I_PADDR == `DDRM_OFF_MODE
		|| I_PADDR == `DDRM_OFF_EMODE || I_PADDR == `DDRM_OFF_STAT;
	assign stat_wr = I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == `DDRM_OFF_STAT;
	assign O_PREADY = 1'b1;
	assign O_PSLVERR = I_PSEL && I_PENABLE && !hit;

	always_comb begin
		rdata = '0;
		unique case (I_PADDR)
			`DDRM_OFF_CTRL: rdata = {31'h0, ctrl_en_r};
			`DDRM_OFF_MODE: rdata = {18'h0, mode_r};
			`DDRM_OFF_EMODE: rdata = {18'h0, emode_r};
			`DDRM_OFF_STAT: rdata = {dll_cnt_r, 15'h0, err_r, 1'h0,
				dll_cnt_r == `DDRM_DLL_CYC, |wr_act, rd_on_r | (rd_wait_r != 3'h0), open_r};
			default: rdata = '0;
		endcase
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_PRDATA <= '0;
			ctrl_en_r <= `DDRM_CTRL_RST;
		end else begin
			if (I_PSEL && !I_PENABLE)
				O_PRDATA <= rdata;
			if (I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == `DDRM_OFF_CTRL)
				ctrl_en_r <= I_PWDATA[0];
		end
	end

	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RST_N);

	sequence s_rd_cmd;
		cmd == ddrm_pkg::CMD_RD && open_r[ba_s];
	endsequence
	property p_row_latch;
		cmd == ddrm_pkg::CMD_ACT |=> open_r[$past(ba_s)] && row_r[$past(ba_s)] == $past(a_s);
	endproperty
	a_row_latch: assert property (p_row_latch) else $error("row not latched");
	property p_mode_load;
		cmd == ddrm_pkg::CMD_LMR && ba_s == `DDRM_BA_MR |=>
			mode_r == $past(a_s) ##1
			mode_r[`DDRM_MR_OP] == {$past(a_s[13:9], 2), 1'b0, $past(a_s[7], 2)}
			&& mode_r[`DDRM_MR_BL] == $past(a_s[2:0], 2);
	endproperty
	a_mode_load: assert property (p_mode_load) else $error("mode not loaded");
	property p_dll_clear;
		mode_r[`DDRM_MR_DLLRST] |=> !mode_r[`DDRM_MR_DLLRST];
	endproperty
	a_dll_clear: assert property (p_dll_clear) else $error("DLL bit kept");
	property p_cs_mask;
		ck_rise && cs_n_s |-> cmd == ddrm_pkg::CMD_NOP;
	endproperty
	a_cs_mask: assert property (p_cs_mask) else $error("command under CS high");
	property p_latency;
		s_rd_cmd ##1 (rd_wait_r == `DDRM_CL2_HALF) |-> !O_DQ_OE [*8];
	endproperty
	a_latency: assert property (p_latency) else $error("early read data");
	property p_strobe_dir;
		O_DQ_OE |-> &O_DQS_OE && (rd_on_r || rd_wait_r == 3'h0);
	endproperty
	a_strobe_dir: assert property (p_strobe_dir) else $error("strobe not driven");
	property p_word_pair;
		ck_edge && cmd != ddrm_pkg::CMD_RD && rd_on_r && rd_idx_r[0] && rd_idx_r != bl_len
			|=> O_DQ == $past(hold_r);
	endproperty
	a_word_pair: assert property (p_word_pair) else $error("second half lost");
	property p_mlmr_no_rd;
		cmd == ddrm_pkg::CMD_LMR |=> !O_DQ_OE || $stable(O_DQ) || ck_edge;
	endproperty
	a_mlmr_no_rd: assert property (p_mlmr_no_rd) else $error("data moved by mode load");
	property p_reserved;
		cmd == ddrm_pkg::CMD_LMR && ba_s == `DDRM_BA_MR && a_s[13:9] != 5'h0 |=> err_r;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved mode not flagged");
	property p_burst_end;
		rd_on_r && rd_idx_r == bl_len && ck_edge |=> !O_DQ_OE;
	endproperty
	a_burst_end: assert property (p_burst_end) else $error("burst overran");
endmodule // ddrm_core

// ==== ddrm_defines.svh ====
/*
 Constants of the DDR SDRAM device model: register map, mode register
 fields and codes, and cycle counts. Assumes inclusion by bare name.
*/
`ifndef DDRM_DEFINES_SVH
`define DDRM_DEFINES_SVH
`define DDRM_OFF_CTRL 8'h00
`define DDRM_OFF_MODE 8'h04
`define DDRM_OFF_EMODE 8'h08
`define DDRM_OFF_STAT 8'h0C
`define DDRM_CTRL_RST 1'h1
`define DDRM_MR_BL 2:0
`define DDRM_MR_BT 3
`define DDRM_MR_CL 6:4
`define DDRM_MR_OP 13:7
`define DDRM_MR_DLLRST 8
`define DDRM_OP_NORMAL 7'h00
`define DDRM_OP_DLLRST 7'h02
`define DDRM_CL2 3'h2
`define DDRM_CL25 3'h6
`define DDRM_CL2_HALF 3'h4
`define DDRM_CL25_HALF 3'h5
`define DDRM_BA_MR 2'h0
`define DDRM_BA_EMR 2'h1
`define DDRM_AP_BIT 10
`define DDRM_DLL_CYC 8'hC8
`define DDRM_ST_ERR 8
`endif

// ==== ddrm_pkg.sv ====
/*
 Types of the DDR SDRAM device model: the decoded command set.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package ddrm_pkg;
	typedef enum logic [2:0] {
		CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_LMR, CMD_BST
	} ddrm_cmd_e;
endpackage

// ==== ddrm_ctl_model.sv ====
/* Controller model on the DDR pins: free clock, commands, strobed write
 bursts and read capture. Assumes the bench calls its tasks by hierarchy. */
`timescale 1ns/1ps
module ddrm_ctl_model #(
	parameter int REF_GAP = 16
) (
	// Device side
	input wire logic i_clk,
	input wire logic [15:0] i_dq,
	input wire logic i_dq_oe,
	input wire logic [1:0] i_dqs,
	input wire logic [1:0] i_dqs_oe,
	// Pins toward device
	output logic o_ck,
	output logic o_cke,
	output logic o_cs_n,
	output logic o_ras_n,
	output logic o_cas_n,
	output logic o_we_n,
	output logic [1:0] o_ba,
	output logic [13:0] o_a,
	output logic [15:0] o_dq,
	output logic [1:0] o_dqs,
	output logic [1:0] o_dm
);
	logic [15:0] dq_d = 16'h0000;
	logic [1:0] dqs_d = 2'h0;
	logic drv = 1'b0;
	logic last_dqs = 1'b0;
	logic [15:0] rd_q[$];
	time t_cmd;
	time t_q0;
	// Released lines show the inverse of the last value, never a held copy
	assign o_dq = i_dq_oe ? i_dq : (drv ? dq_d : ~dq_d);
	assign o_dqs = (i_dqs_oe & i_dqs) | (~i_dqs_oe & (drv ? dqs_d : ~dqs_d));
	initial begin
		o_cke = 1'b0;
		{o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hF;
		o_ba = 2'h0;
		o_a = 14'h0000;
		o_dm = 2'h0;
		o_ck = 1'b0;
		#3;
		forever #80 o_ck = ~o_ck;
	end
	always @(posedge i_clk) begin
		if (i_dq_oe && i_dqs[0] !== last_dqs) begin
			if (rd_q.size() == 0) t_q0 = $time;
			rd_q.push_back(i_dq);
		end
		last_dqs <= i_dqs[0];
	end
	task automatic cmd(input logic [2:0] c, input logic [1:0] ba, input logic [13:0] a,
			input logic cs);
		@(negedge o_ck);
		{o_cs_n, o_ras_n, o_cas_n, o_we_n} = {cs, c};
		o_ba = ba;
		o_a = a;
		@(posedge o_ck) t_cmd = $time;
		@(negedge o_ck);
		{o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'h7;
	endtask
	task automatic init(input logic [13:0] md);
		#200000;
		cmd(3'h7, 2'h0, 14'h0000, 1'b1);
		o_cke = 1'b1;
		cmd(3'h2, 2'h0, 14'h0400, 1'b0);
		cmd(3'h0, 2'h1, 14'h0000, 1'b0);
		cmd(3'h0, 2'h0, md | 14'h0100, 1'b0);
		cmd(3'h2, 2'h0, 14'h0400, 1'b0);
		repeat (2) begin
			cmd(3'h1, 2'h0, 14'h0000, 1'b0);
			repeat (REF_GAP) @(negedge o_ck);
		end
		cmd(3'h0, 2'h0, md, 1'b0);
		repeat (200) @(negedge o_ck);
	endtask
	// Preamble goes low before the command so its edge precedes the burst
	task automatic wr(input logic [1:0] ba, input logic [13:0] col, input logic [15:0] w[8],
			input logic [1:0] m[8], input int n);
		drv = 1'b1;
		dqs_d = 2'h0;
		dq_d = w[0];
		cmd(3'h4, ba, col, 1'b0);
		for (int i = 0; i < n; i++) begin
			dq_d = w[i];
			o_dm = m[i];
			#40 dqs_d = ~dqs_d;
			#40;
		end
		drv = 1'b0;
	endtask
	task automatic rd(input logic [1:0] ba, input logic [13:0] col, input int n);
		rd_q.delete();
		cmd(3'h5, ba, col, 1'b0);
		for (int i = 0; i < 400 && rd_q.size() < n; i++) @(posedge i_clk);
	endtask
endmodule // ddrm_ctl_model

// ==== ddr_sdram_init_and_mode_tb.sv ====
/* Self-checking bench of ddrm_core: APB register checks and DDR traffic.
 Assumes ddrm_ctl_model drives the DDR pins. */
`timescale 1ns/1ps
`include "ddrm_defines.svh"
module ddr_sdram_init_and_mode_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, ck, cke, cs_n, ras_n, cas_n, we_n, dq_oe;
	logic [1:0] ba, dqs_in, dqs_out, dqs_oe, dm;
	logic [13:0] a;
	logic [15:0] dq_in, dq_out;
	logic [15:0] mem[8];
	logic [15:0] w[8];
	logic [1:0] m[8];
	int bad_count = 0;
	int compares = 0;
	int cyc = 0;
	always #5 clk = ~clk;
	ddrm_core #(.COL_W(4), .LANES(2)) dut (
		.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_CK(ck), .I_CKE(cke), .I_CS_N(cs_n),
		.I_RAS_N(ras_n), .I_CAS_N(cas_n), .I_WE_N(we_n), .I_BA(ba), .I_A(a),
		.I_DQ(dq_in), .O_DQ(dq_out), .O_DQ_OE(dq_oe), .I_DQS(dqs_in), .O_DQS(dqs_out),
		.O_DQS_OE(dqs_oe), .I_DM(dm));
	ddrm_ctl_model ctl (
		.i_clk(clk), .i_dq(dq_out), .i_dq_oe(dq_oe), .i_dqs(dqs_out), .i_dqs_oe(dqs_oe),
		.o_ck(ck), .o_cke(cke), .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n),
		.o_we_n(we_n), .o_ba(ba), .o_a(a), .o_dq(dq_in), .o_dqs(dqs_in), .o_dm(dm));
	task automatic give_verdict();
		if (bad_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rr(input logic [7:0] ad, input logic [31:0] mask, input logic [31:0] exp);
		apb(1'b0, ad, 32'h0);
		chk(rd & mask, exp);
	endtask
	// Column order inside the aligned block of length n
	function automatic int ord(input int s, input int i, input int n, input logic itl);
		return itl ? (s ^ i) : ((s & ~(n - 1)) | ((s + i) & (n - 1)));
	endfunction
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			bad_count++;
			give_verdict();
		end
	end
	initial begin
		int n, s, c;
		logic bt;
		logic [2:0] cl;
		logic [13:0] md;
		void'($urandom(32'hB5EABBF4));
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rr(`DDRM_OFF_CTRL, 32'hFFFFFFFF, 32'h1);
		rr(`DDRM_OFF_MODE, 32'hFFFFFFFF, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h0, err}, 32'h1);
		ctl.init(14'h0022);
		rr(`DDRM_OFF_MODE, 32'h3FFF, 32'h22);
		ctl.cmd(3'h0, `DDRM_BA_MR, 14'h0122, 1'b0);
		rr(`DDRM_OFF_MODE, 32'h3FFF, 32'h22);
		rr(`DDRM_OFF_STAT, 32'h40, 32'h0);
		md = 14'($urandom) & 14'h3FFE;
		ctl.cmd(3'h0, `DDRM_BA_EMR, md, 1'b0);
		rr(`DDRM_OFF_EMODE, 32'h3FFF, {18'h0, md});
		ctl.cmd(3'h0, `DDRM_BA_MR, 14'h00A2, 1'b0);
		rr(`DDRM_OFF_MODE, 32'h3FFF, 32'hA2);
		rr(`DDRM_OFF_STAT, 32'h100, 32'h100);
		apb(1'b1, `DDRM_OFF_STAT, 32'h100);
		rr(`DDRM_OFF_STAT, 32'h100, 32'h0);
		ctl.cmd(3'h3, 2'h2, 14'h0005, 1'b1);
		rr(`DDRM_OFF_STAT, 32'hF, 32'h0);
		apb(1'b1, `DDRM_OFF_CTRL, 32'h0);
		ctl.cmd(3'h3, 2'h2, 14'h0005, 1'b0);
		rr(`DDRM_OFF_STAT, 32'hF, 32'h0);
		apb(1'b1, `DDRM_OFF_CTRL, 32'h1);
		// The DLL reset above needs its lock time before the first read
		repeat (200) @(posedge ck);
		rr(`DDRM_OFF_STAT, 32'h40, 32'h40);
		// First pass is BL8 unmasked so every later masked byte has a known old value
		for (int k = 0; k < 12; k++) begin
			bt = (k >= 6);
			cl = (k % 6 < 3) ? `DDRM_CL2 : `DDRM_CL25;
			n = 8 >> (k % 3);
			md = {7'h00, cl, bt, 1'b0, 2'(3 - k % 3)};
			ctl.cmd(3'h2, 2'h0, 14'h0400, 1'b0);
			ctl.cmd(3'h0, `DDRM_BA_MR, md, 1'b0);
			rr(`DDRM_OFF_MODE, 32'h3FFF, {18'h0, md});
			ctl.cmd(3'h3, 2'h1, 14'($urandom), 1'b0);
			rr(`DDRM_OFF_STAT, 32'hF, 32'h2);
			s = $urandom_range(n - 1);
			for (int i = 0; i < n; i++) begin
				w[i] = 16'($urandom);
				m[i] = (k == 0) ? 2'h0 : 2'($urandom);
				c = ord(s, i, n, bt);
				if (!m[i][0]) mem[c][7:0] = w[i][7:0];
				if (!m[i][1]) mem[c][15:8] = w[i][15:8];
			end
			ctl.wr(2'h1, 14'(s), w, m, n);
			s = $urandom_range(n - 1);
			ctl.rd(2'h1, 14'(s), n);
			chk(ctl.rd_q.size(), n);
			for (int i = 0; i < n; i++) begin
				chk(ctl.rd_q[i], mem[ord(s, i, n, bt)]);
			end
			c = int'(ctl.t_q0 - ctl.t_cmd) - (cl == `DDRM_CL2 ? 320 : 400);
			chk(c >= 0 && c < 80, 1);
		end
		give_verdict();
	end
endmodule // ddr_sdram_init_and_mode_tb
